// ===== src/dlui_pkg.sv
/*
 * Constants, register map and types of the data logger user interface block.
 * Assumes a 25 MHz mclk and a host that reaches the registers over a plain strobe port.
 */
// Functional notes
// (RL1) Display button cycles readings, date, time, count
// (RL2) Alarm flashes; display button dismisses until next
// (RL3) Unit button toggles Celsius and Fahrenheit
// (RL4) Logging button inverts logging enable
// (RL5) Log only while enabled; sampling always continues
// (RL6) Indicator LED blinks on every sample
// (RL7) LED rests on when host connected
// (RL8) Date shows month/day/year with slashes
// (RL9) Time shows h:m:s plus A or P
// (RL10) Count view shows count, dot when logging
// (RL11) Alarm shows value and HI or LOW
// (RL12) Both alarms active: messages alternate
// (RL13) Sensor link failure raises error message alarm
// (RL14) Alarm pin idles high, low 500 ms
// (RL15) Five views including alarm
// (RL16) Alarm above high or below low threshold
// (RL17) Unset thresholds ignored; none set, no alarms
// (RL18) Buttons synchronised, debounced, one action each
// (RL19) Unit affects display only, not comparisons
package dlui_pkg;

  // ********************
  // Timing
  // ********************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PULSE_MS = 500;
  localparam int unsigned BLINK_MS = 50;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned DEB_MS = 20;
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_CYC = DEB_MS * (CLK_HZ / 1000);

  // ********************
  // Register map
  // ********************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_HUM_HI = 8'h0c;
  localparam logic [7:0] REG_HUM_LO = 8'h10;
  localparam logic [7:0] REG_TEMP_HI = 8'h14;
  localparam logic [7:0] REG_TEMP_LO = 8'h18;
  localparam logic [7:0] REG_COUNT = 8'h1c;
  localparam logic [7:0] REG_ALARM = 8'h20;
  localparam int CTRL_LOG = 0;
  localparam int CTRL_HOST = 1;
  localparam int CTRL_UNIT = 2;
  localparam int THR_EN = 16;
  localparam int ST_ALARM = 0;
  localparam int ST_COMM = 1;
  localparam int ST_LOG = 2;
  localparam int ST_W = 3;
  localparam logic [16:0] THR_RESET = 17'h00000;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
  localparam int BTN_DISP = 0;
  localparam int BTN_UNIT = 1;
  localparam int BTN_LOG = 2;

  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {VIEW_READ, VIEW_DATE, VIEW_TIME, VIEW_COUNT, VIEW_ALARM} dlui_view_type;
  typedef enum logic [1:0] {TAG_NONE, TAG_OVER, TAG_UNDER, TAG_LINK_ERR} dlui_tag_type;
  typedef enum logic [1:0] {SEP_NONE, SEP_SLASH, SEP_COLON} dlui_sep_type;

  // Tenths of a degree Celsius to tenths of Fahrenheit
  function automatic logic signed [15:0] dlui_to_fahr(input logic signed [15:0] c);
    logic signed [19:0] w;
    w = ($signed({{4{c[15]}}, c}) * 20'sd9) / 20'sd5 + 20'sd320;
    return w[15:0];
  endfunction

endpackage

// ===== src/dlui_debounce.sv
/*
 * Button synchroniser and debouncer, one press pulse per settled press.
 * Assumes raw button levels are asynchronous and active high.
 */
`timescale 1ns/1ps
module dlui_debounce #(
  parameter int N = 3,
  parameter int unsigned CYC = 500000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Buttons
  input wire logic [N-1:0] raw,
  output logic [N-1:0] press
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [N-1:0] sync1_q, sync2_q, stable_q, press_q;

  // ********************
  // Two flops before any logic
  // ********************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= raw; // [RL18]
      sync2_q <= sync1_q;
    end
  end

  // ********************
  // Settle counters
  // ********************
  for (genvar i = 0; i < N; i++) begin : g_btn
    logic [CW-1:0] cnt_q;
    wire settled = (sync2_q[i] != stable_q[i]) && (cnt_q == LAST);
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        cnt_q <= '0;
        stable_q[i] <= 1'b0;
        press_q[i] <= 1'b0;
      end else if (clk_en) begin
        // Bounce restarts the count, so one press gives one pulse [RL18]
        cnt_q <= (sync2_q[i] == stable_q[i] || settled) ? '0 : cnt_q + 1'b1;
        if (settled) stable_q[i] <= sync2_q[i];
        press_q[i] <= settled & sync2_q[i];
      end
    end
  end

  assign press = press_q;

endmodule

// ===== src/dlui_top.sv
/*
 * Data logger user interface: buttons, views, alarms, indicator LED,
 * alarm pin, log gating and a small register file with interrupt.
 * Assumes the sampler, clock calendar and log memory share mclk.
 */
`timescale 1ns/1ps
module dlui_top
  import dlui_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = dlui_pkg::DEB_CYC,
  parameter int unsigned BLINK_CYCLES = dlui_pkg::BLINK_CYC,
  parameter int unsigned PULSE_CYCLES = dlui_pkg::PULSE_CYC,
  parameter int unsigned FLASH_CYCLES = dlui_pkg::FLASH_CYC,
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Buttons
  input wire logic display_select_button,
  input wire logic unit_toggle_button,
  input wire logic logging_toggle_button,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Sampler
  input wire logic sample_strobe,
  input wire logic signed [15:0] sample_temp,
  input wire logic [15:0] sample_hum,
  input wire logic sensor_error,
  // Calendar
  input wire logic [3:0] rtc_month,
  input wire logic [4:0] rtc_day,
  input wire logic [6:0] rtc_year,
  input wire logic [3:0] rtc_hour,
  input wire logic [5:0] rtc_minute,
  input wire logic [5:0] rtc_second,
  input wire logic rtc_pm,
  // Log memory
  output logic log_write,
  output logic [COUNT_W-1:0] log_index,
  output logic signed [15:0] log_temp,
  output logic [15:0] log_hum,
  // Indicators
  output logic sample_indicator_led,
  output logic alarm_output_pin_n,
  // Display
  output dlui_pkg::dlui_view_type lcd_view,
  output logic lcd_visible,
  output logic [15:0] lcd_value_a,
  output logic [15:0] lcd_value_b,
  output logic [15:0] lcd_value_c,
  output dlui_pkg::dlui_sep_type lcd_sep,
  output dlui_pkg::dlui_tag_type lcd_tag,
  output logic lcd_dot,
  output logic lcd_unit_f,
  output logic lcd_pm
);
  import dlui_pkg::*;

  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int FW = $clog2(FLASH_CYCLES + 1);

  // ********************
  // Buttons
  // ********************
  logic [2:0] press;
  dlui_debounce #(.N(3), .CYC(DEB_CYCLES)) u_deb (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .raw({logging_toggle_button, unit_toggle_button, display_select_button}),
    .press(press)
  );

  // ********************
  // State
  // ********************
  logic log_en_q, unit_f_q, host_q, shown_q, alt_q, flash_on_q;
  dlui_view_type view_q, view_d;
  logic [16:0] hum_hi_q, hum_lo_q, temp_hi_q, temp_lo_q;
  logic [ST_W-1:0] stat_q, mask_q;
  logic [COUNT_W-1:0] count_q;
  logic t_alarm_q, t_over_q, h_alarm_q, h_over_q, comm_q;
  logic signed [15:0] t_val_q;
  logic [15:0] h_val_q;
  logic [BW-1:0] blink_q;
  logic [PW-1:0] pulse_q;
  logic [FW-1:0] flash_q;
  logic [31:0] rdata_q;

  // ********************
  // Register decode
  // ********************
  wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
  wire wr_stat = reg_wr && reg_addr == REG_STATUS;
  wire wr_mask = reg_wr && reg_addr == REG_MASK;
  wire wr_hhi = reg_wr && reg_addr == REG_HUM_HI;
  wire wr_hlo = reg_wr && reg_addr == REG_HUM_LO;
  wire wr_thi = reg_wr && reg_addr == REG_TEMP_HI;
  wire wr_tlo = reg_wr && reg_addr == REG_TEMP_LO;
  wire erase = reg_wr && reg_addr == REG_COUNT;
  logic [31:0] rd_mux;
  always_comb begin
    if (reg_addr == REG_CTRL) begin
      rd_mux = {29'h0, unit_f_q, host_q, log_en_q};
    end else if (reg_addr == REG_STATUS) begin
      rd_mux = {29'h0, stat_q};
    end else if (reg_addr == REG_MASK) begin
      rd_mux = {29'h0, mask_q};
    end else if (reg_addr == REG_HUM_HI) begin
      rd_mux = {15'h0, hum_hi_q};
    end else if (reg_addr == REG_HUM_LO) begin
      rd_mux = {15'h0, hum_lo_q};
    end else if (reg_addr == REG_TEMP_HI) begin
      rd_mux = {15'h0, temp_hi_q};
    end else if (reg_addr == REG_TEMP_LO) begin
      rd_mux = {15'h0, temp_lo_q};
    end else if (reg_addr == REG_COUNT) begin
      rd_mux = 32'(count_q);
    end else if (reg_addr == REG_ALARM) begin
      rd_mux = {27'h0, comm_q, h_over_q, h_alarm_q, t_over_q, t_alarm_q};
    end else begin
      // Unmapped reads return zero
      rd_mux = 32'h0;
    end
  end

  // ********************
  // Threshold checks
  // ********************
  // Compared in Celsius tenths so the display unit cannot move an alarm [RL19]
  wire th_hi = hum_hi_q[THR_EN] && sample_hum > hum_hi_q[15:0]; // [RL16] [RL17]
  wire th_lo = hum_lo_q[THR_EN] && sample_hum < hum_lo_q[15:0]; // [RL16] [RL17]
  wire tt_hi = temp_hi_q[THR_EN] && sample_temp > $signed(temp_hi_q[15:0]); // [RL16] [RL17]
  wire tt_lo = temp_lo_q[THR_EN] && sample_temp < $signed(temp_lo_q[15:0]); // [RL16] [RL17]
  wire t_hit = !sensor_error && (tt_hi || tt_lo);
  wire h_hit = !sensor_error && (th_hi || th_lo);
  wire alarm_event = sample_strobe && (t_hit || h_hit || sensor_error); // [RL13]
  wire log_take = sample_strobe && log_en_q && !sensor_error; // [RL5]
  wire disp_press = press[BTN_DISP];
  wire [ST_W-1:0] events = {press[BTN_LOG], sample_strobe && sensor_error, alarm_event};
  wire flash_wrap = flash_q == FW'(FLASH_CYCLES - 1);

  // ********************
  // View selection
  // ********************
  always_comb begin
    view_d = view_q;
    if (disp_press && !shown_q) begin
      case (view_q)
        VIEW_READ: view_d = VIEW_DATE; // [RL1]
        VIEW_DATE: view_d = VIEW_TIME;
        VIEW_TIME: view_d = VIEW_COUNT;
        default: view_d = VIEW_READ;
      endcase
    end
  end

  // ********************
  // Controls and registers
  // ********************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      log_en_q <= 1'b0;
      unit_f_q <= 1'b0;
      host_q <= 1'b0;
      view_q <= VIEW_READ;
      shown_q <= 1'b0;
      mask_q <= MASK_RESET;
      stat_q <= '0;
      hum_hi_q <= THR_RESET;
      hum_lo_q <= THR_RESET;
      temp_hi_q <= THR_RESET;
      temp_lo_q <= THR_RESET;
      rdata_q <= 32'h0;
    end else if (clk_en) begin
      // A control register write beats a unit or logging button press in the same cycle
      if (wr_ctrl) begin
        log_en_q <= reg_wdata[CTRL_LOG];
        unit_f_q <= reg_wdata[CTRL_UNIT];
        host_q <= reg_wdata[CTRL_HOST];
      end else begin
        if (press[BTN_LOG]) log_en_q <= !log_en_q; // [RL4]
        if (press[BTN_UNIT]) unit_f_q <= !unit_f_q; // [RL3]
      end
      view_q <= view_d;
      // New alarm wins over a dismiss in the same cycle [RL2]
      if (alarm_event) shown_q <= 1'b1;
      else if (sample_strobe || disp_press) shown_q <= 1'b0;
      if (wr_mask) mask_q <= reg_wdata[ST_W-1:0];
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata[ST_W-1:0] : '0)) | events;
      if (wr_hhi) hum_hi_q <= reg_wdata[16:0];
      if (wr_hlo) hum_lo_q <= reg_wdata[16:0];
      if (wr_thi) temp_hi_q <= reg_wdata[16:0];
      if (wr_tlo) temp_lo_q <= reg_wdata[16:0];
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(stat_q & mask_q);

  // ********************
  // Sample results and log
  // ********************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      t_alarm_q <= 1'b0;
      t_over_q <= 1'b0;
      h_alarm_q <= 1'b0;
      h_over_q <= 1'b0;
      comm_q <= 1'b0;
      t_val_q <= 16'sh0000;
      h_val_q <= 16'h0000;
      count_q <= '0;
      log_write <= 1'b0;
      log_index <= '0;
      log_temp <= 16'sh0000;
      log_hum <= 16'h0000;
    end else if (clk_en) begin
      if (sample_strobe) begin
        t_alarm_q <= t_hit;
        t_over_q <= tt_hi;
        h_alarm_q <= h_hit;
        h_over_q <= th_hi;
        comm_q <= sensor_error; // [RL13]
        t_val_q <= sample_temp;
        h_val_q <= sample_hum;
      end
      // Count saturates rather than wrapping back to zero
      if (erase) count_q <= '0;
      else if (log_take && ~&count_q) count_q <= count_q + 1'b1; // [RL5]
      log_write <= log_take;
      log_index <= count_q;
      log_temp <= sample_temp;
      log_hum <= sample_hum;
    end
  end

  // ********************
  // LED, alarm pin and flash timers
  // ********************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blink_q <= '0;
      pulse_q <= '0;
      flash_q <= '0;
      flash_on_q <= 1'b1;
      alt_q <= 1'b0;
    end else if (clk_en) begin
      if (sample_strobe) blink_q <= BW'(BLINK_CYCLES); // [RL6]
      else if (blink_q != '0) blink_q <= blink_q - 1'b1;
      if (alarm_event) pulse_q <= PW'(PULSE_CYCLES); // [RL14]
      else if (pulse_q != '0) pulse_q <= pulse_q - 1'b1;
      flash_q <= flash_wrap ? '0 : flash_q + 1'b1;
      if (flash_wrap) flash_on_q <= !flash_on_q;
      // One full on and off period per message [RL12]
      if (flash_wrap && !flash_on_q) alt_q <= !alt_q;
    end
  end

  // Blink is the inverse of the resting level so it shows either way
  assign sample_indicator_led = (blink_q != '0) ? !host_q : host_q; // [RL6] [RL7]
  assign alarm_output_pin_n = pulse_q == '0; // [RL14]

  // ********************
  // Display contents
  // ********************
  wire both = t_alarm_q && h_alarm_q;
  wire show_t = t_alarm_q && !(both && alt_q); // [RL12]
  wire signed [15:0] t_shown = unit_f_q ? dlui_to_fahr(t_val_q) : t_val_q; // [RL3] [RL19]
  dlui_view_type v_d;
  logic [15:0] a_d, b_d, c_d;
  dlui_sep_type s_d;
  dlui_tag_type g_d;
  always_comb begin
    v_d = shown_q ? VIEW_ALARM : view_q; // [RL15]
    a_d = 16'h0000;
    b_d = 16'h0000;
    c_d = 16'h0000;
    s_d = SEP_NONE;
    g_d = TAG_NONE;
    case (v_d)
      VIEW_READ: begin
        a_d = t_shown;
        b_d = h_val_q;
      end
      VIEW_DATE: begin
        a_d = {12'h000, rtc_month}; // [RL8]
        b_d = {11'h000, rtc_day};
        c_d = {9'h000, rtc_year};
        s_d = SEP_SLASH;
      end
      VIEW_TIME: begin
        a_d = {12'h000, rtc_hour}; // [RL9]
        b_d = {10'h000, rtc_minute};
        c_d = {10'h000, rtc_second};
        s_d = SEP_COLON;
      end
      VIEW_COUNT: a_d = 16'(count_q); // [RL10]
      default: begin
        if (comm_q) begin
          g_d = TAG_LINK_ERR; // [RL13]
        end else if (show_t) begin
          a_d = t_shown; // [RL11]
          g_d = t_over_q ? TAG_OVER : TAG_UNDER;
        end else begin
          a_d = h_val_q; // [RL11]
          g_d = h_over_q ? TAG_OVER : TAG_UNDER;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lcd_view <= VIEW_READ;
      lcd_visible <= 1'b1;
      lcd_value_a <= 16'h0000;
      lcd_value_b <= 16'h0000;
      lcd_value_c <= 16'h0000;
      lcd_sep <= SEP_NONE;
      lcd_tag <= TAG_NONE;
      lcd_dot <= 1'b0;
      lcd_unit_f <= 1'b0;
      lcd_pm <= 1'b0;
    end else if (clk_en) begin
      lcd_view <= v_d;
      lcd_visible <= !shown_q || flash_on_q; // [RL2]
      lcd_value_a <= a_d;
      lcd_value_b <= b_d;
      lcd_value_c <= c_d;
      lcd_sep <= s_d;
      lcd_tag <= g_d;
      lcd_dot <= v_d == VIEW_COUNT && log_en_q; // [RL10]
      lcd_unit_f <= unit_f_q;
      lcd_pm <= v_d == VIEW_TIME && rtc_pm; // [RL9]
    end
  end

  // ********************
  // Checks
  // ********************
  property p_view_wrap;
    @(posedge mclk) disable iff (reset)
    clk_en && disp_press && !shown_q && view_q == VIEW_COUNT |=> view_q == VIEW_READ;
  endproperty
  a_view_wrap: assert property (p_view_wrap) else $error("count view did not wrap"); // [RL1]

  property p_dismiss;
    @(posedge mclk) disable iff (reset)
    clk_en && shown_q && disp_press && !alarm_event |=> !shown_q ##1 lcd_view != VIEW_ALARM;
  endproperty
  a_dismiss: assert property (p_dismiss) else $error("alarm not dismissed"); // [RL2]

  property p_unit;
    @(posedge mclk) disable iff (reset)
    clk_en && press[BTN_UNIT] && !wr_ctrl |=> unit_f_q != $past(unit_f_q);
  endproperty
  a_unit: assert property (p_unit) else $error("unit did not toggle"); // [RL3]

  property p_log_toggle;
    @(posedge mclk) disable iff (reset)
    clk_en && press[BTN_LOG] && !wr_ctrl |=> log_en_q != $past(log_en_q) ##1 stat_q[ST_LOG];
  endproperty
  a_log_toggle: assert property (p_log_toggle) else $error("logging did not toggle"); // [RL4]

  property p_no_log;
    @(posedge mclk) disable iff (reset)
    clk_en && sample_strobe && !log_en_q && !erase |=> $stable(count_q) && !log_write;
  endproperty
  a_no_log: assert property (p_no_log) else $error("sample logged while disabled"); // [RL5]

  property p_blink;
    @(posedge mclk) disable iff (reset)
    clk_en && sample_strobe |=> sample_indicator_led != host_q;
  endproperty
  a_blink: assert property (p_blink) else $error("no blink on sample"); // [RL6]

  property p_rest;
    @(posedge mclk) disable iff (reset)
    clk_en && wr_ctrl && blink_q == '0 && !sample_strobe |=> sample_indicator_led == $past(reg_wdata[CTRL_HOST]);
  endproperty
  a_rest: assert property (p_rest) else $error("LED rest level wrong"); // [RL7]

  property p_pin;
    @(posedge mclk) disable iff (reset)
    clk_en && alarm_event |=> !alarm_output_pin_n && pulse_q == PW'(PULSE_CYCLES);
  endproperty
  a_pin: assert property (p_pin) else $error("alarm pin not pulsed"); // [RL14]

  property p_unset;
    @(posedge mclk) disable iff (reset)
    !hum_hi_q[THR_EN] && !hum_lo_q[THR_EN] && !temp_hi_q[THR_EN] && !temp_lo_q[THR_EN] && !sensor_error
      |-> !alarm_event;
  endproperty
  a_unset: assert property (p_unset) else $error("alarm with no thresholds"); // [RL17]

  property p_comm;
    @(posedge mclk) disable iff (reset)
    clk_en && sample_strobe && sensor_error |=> comm_q && shown_q ##1 lcd_tag == TAG_LINK_ERR;
  endproperty
  a_comm: assert property (p_comm) else $error("link error not shown"); // [RL13]

endmodule

// ===== sim/dlui_far_model.sv
/*
 * Far-side model: sensor sampler and the three push buttons, with contact bounce.
 * Assumes the bench calls its tasks and that it shares mclk with the design.
 */
`timescale 1ns/1ps
module dlui_far_model (
  // Clock
  input wire logic mclk,
  // Sampler
  output logic sample_strobe,
  output logic signed [15:0] sample_temp,
  output logic [15:0] sample_hum,
  output logic sensor_error,
  // Buttons
  output logic [2:0] btn
);
  initial begin
    sample_strobe = 1'b0;
    sample_temp = 16'h0000;
    sample_hum = 16'h0000;
    sensor_error = 1'b0;
    btn = 3'h0;
  end

  // ********************
  // Sampler
  // ********************
  // Data is scrambled after the strobe so that stale values never pass as valid
  task automatic sample(input logic signed [15:0] t, input logic [15:0] h, input logic e);
    @(posedge mclk);
    sample_strobe <= 1'b1;
    sample_temp <= t;
    sample_hum <= h;
    sensor_error <= e;
    @(posedge mclk);
    sample_strobe <= 1'b0;
    sample_temp <= ~t;
    sample_hum <= ~h;
    sensor_error <= ~e;
  endtask

  // ********************
  // Buttons
  // ********************
  // Bounce on make, then a held press and a clean release
  task automatic press(input int b, input int hold);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      btn[b] <= i[0];
    end
    repeat (hold) @(posedge mclk);
    btn[b] <= 1'b0;
    repeat (hold) @(posedge mclk);
  endtask
endmodule

// ===== sim/tb.sv
/*
 * Self-checking bench of the data logger user interface.
 * Assumes short debounce, blink, pulse and flash counts set at the instance.
 */
`timescale 1ns/1ps
module tb;
  import dlui_pkg::*;
  localparam int DEB = 4;
  localparam int BLINK = 6;
  localparam int PULSE = 10;
  localparam int FLASH = 8;
  logic mclk;
  logic reset;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] r;
  logic reg_wr;
  logic reg_rd;
  logic irq;
  logic strobe;
  logic serr;
  logic log_write;
  logic led;
  logic pin_n;
  logic signed [15:0] stemp;
  logic signed [15:0] log_temp;
  logic [15:0] shum;
  logic [15:0] log_hum;
  logic [15:0] lidx;
  logic ce;
  logic [15:0] va;
  logic [15:0] vb;
  logic [15:0] vc;
  logic [2:0] btn;
  logic [3:0] month;
  logic [3:0] hour;
  logic [4:0] day;
  logic [6:0] year;
  logic [5:0] minute;
  logic [5:0] second;
  logic pm;
  logic visible;
  logic dot;
  logic unit_f;
  logic lcd_pm;
  logic le;
  logic ho;
  logic s1;
  logic s2;
  dlui_view_type view;
  dlui_sep_type sep;
  dlui_tag_type tag;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int t;
  int h;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  dlui_far_model dlui_far_model_inst (.mclk(mclk), .sample_strobe(strobe), .sample_temp(stemp),
    .sample_hum(shum), .sensor_error(serr), .btn(btn));

  dlui_top #(.DEB_CYCLES(DEB), .BLINK_CYCLES(BLINK), .PULSE_CYCLES(PULSE), .FLASH_CYCLES(FLASH)) dlui_top_inst (
    .mclk(mclk), .reset(reset), .clk_en(ce), .display_select_button(btn[BTN_DISP]),
    .unit_toggle_button(btn[BTN_UNIT]), .logging_toggle_button(btn[BTN_LOG]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .sample_strobe(strobe), .sample_temp(stemp), .sample_hum(shum), .sensor_error(serr),
    .rtc_month(month), .rtc_day(day), .rtc_year(year), .rtc_hour(hour), .rtc_minute(minute),
    .rtc_second(second), .rtc_pm(pm), .log_write(log_write), .log_index(lidx), .log_temp(log_temp),
    .log_hum(log_hum), .sample_indicator_led(led), .alarm_output_pin_n(pin_n), .lcd_view(view),
    .lcd_visible(visible), .lcd_value_a(va), .lcd_value_b(vb), .lcd_value_c(vc), .lcd_sep(sep),
    .lcd_tag(tag), .lcd_dot(dot), .lcd_unit_f(unit_f), .lcd_pm(lcd_pm));

  // ********************
  // Helpers
  // ********************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic smp(input int tv, input int hv, input logic e);
    dlui_far_model_inst.sample(16'(tv), 16'(hv), e);
    #1;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  function automatic logic [15:0] fahr(input int c);
    return 16'((c * 9) / 5 + 320);
  endfunction

  // ********************
  // Tests
  // ********************
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ce = 1'b1;
    {month, day, year, hour, minute, second, pm} = '0;
    void'($urandom(55338));
    tick(12);
    reset <= 1'b0;
    #1;
    chk({pin_n, led, view}, {1'b1, 1'b0, VIEW_READ}, "reset pins");
    rd(REG_MASK, r);
    chk(r, 64'(MASK_RESET), "mask reset");
    rd(REG_TEMP_HI, r);
    chk(r, 64'(THR_RESET), "threshold reset");
    rd(8'h3c, r);
    chk(r, 0, "unmapped read");
    wr(REG_CTRL, 32'h2);
    chk(led, 1, "host led");
    $display("test reset done");
    wr(REG_COUNT, 32'h0);
    n = 0;
    for (int i = 0; i < 8; i++) begin
      le = 1'($urandom);
      ho = 1'($urandom);
      wr(REG_CTRL, {30'h0, ho, le});
      t = int'($urandom_range(600)) - 200;
      h = int'($urandom_range(1000));
      smp(t, h, 1'b0);
      chk({log_write, led, pin_n}, {le, !ho, 1'b1}, "sample");
      if (le) chk({log_temp, log_hum, lidx}, {16'(t), 16'(h), 16'(n)}, "log data");
      n += le;
      tick(BLINK + 2);
      chk(led, ho, "led rest");
    end
    rd(REG_COUNT, r);
    chk(r, n, "count");
    $display("test sampling done");
    wr(REG_CTRL, 32'h1);
    @(posedge mclk);
    month <= 4'($urandom_range(12, 1));
    day <= 5'($urandom_range(31, 1));
    year <= 7'($urandom_range(99));
    hour <= 4'($urandom_range(12, 1));
    minute <= 6'($urandom_range(59));
    second <= 6'($urandom_range(59));
    pm <= 1'($urandom);
    for (int v = 1; v <= 4; v++) begin
      dlui_far_model_inst.press(BTN_DISP, DEB + 8);
      #1;
      chk(view, v % 4, "view order");
      if (v == 1) chk({va, vb, vc, 14'h0, sep}, {12'h0, month, 11'h0, day, 9'h0, year, 14'h0, SEP_SLASH}, "date");
      if (v == 2) chk({va, vb, vc, 13'h0, lcd_pm, sep}, {12'h0, hour, 10'h0, minute, 10'h0, second, 13'h0, pm, SEP_COLON}, "time");
      if (v == 3) chk({va, dot}, {16'(n), 1'b1}, "count view");
    end
    dlui_far_model_inst.press(BTN_UNIT, DEB + 8);
    wr(REG_TEMP_HI, 32'h0001012c);
    smp(250, 400, 1'b0);
    chk(pin_n, 1, "unit no alarm");
    tick(1);
    chk({unit_f, va, vb}, {1'b1, fahr(250), 16'd400}, "fahrenheit");
    dlui_far_model_inst.press(BTN_UNIT, DEB + 8);
    #1;
    chk({unit_f, va}, {1'b0, 16'd250}, "celsius");
    dlui_far_model_inst.press(BTN_LOG, DEB + 8);
    rd(REG_CTRL, r);
    chk(r[CTRL_LOG], 0, "logging toggle");
    rd(REG_STATUS, r);
    chk(r[ST_LOG], 1, "logging status");
    $display("test buttons done");
    wr(REG_STATUS, 32'h7);
    wr(REG_MASK, 32'h0);
    smp(350, 400, 1'b0);
    chk({pin_n, irq}, 2'b00, "alarm masked");
    n = 0;
    while (pin_n === 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n, PULSE, "pulse length");
    chk({view, tag, va}, {VIEW_ALARM, TAG_OVER, 16'd350}, "alarm view");
    s1 = 1'b0;
    for (int i = 0; i < 2 * FLASH; i++) begin
      tick(1);
      if (visible === 1'b0) s1 = 1'b1;
    end
    chk(s1, 1, "flashing");
    wr(REG_MASK, 32'h1);
    chk(irq, 1, "irq raised");
    wr(REG_STATUS, 32'h1);
    chk(irq, 0, "irq cleared");
    dlui_far_model_inst.press(BTN_DISP, DEB + 8);
    #1;
    chk(view == VIEW_ALARM, 0, "dismiss");
    wr(REG_HUM_HI, 32'h00010320);
    smp(350, 900, 1'b0);
    s1 = 1'b0;
    s2 = 1'b0;
    for (int i = 0; i < 5 * FLASH; i++) begin
      tick(1);
      if (va === 16'd350) s1 = 1'b1;
      if (va === 16'd900) s2 = 1'b1;
    end
    chk({s1, s2}, 2'b11, "alternate");
    wr(REG_TEMP_HI, 32'h0);
    wr(REG_HUM_HI, 32'h0);
    wr(REG_HUM_LO, 32'h000100c8);
    smp(250, 100, 1'b0);
    tick(1);
    chk({view, tag, va}, {VIEW_ALARM, TAG_UNDER, 16'd100}, "low alarm");
    rd(REG_ALARM, r);
    chk(r, 32'h4, "alarm flags");
    smp(0, 0, 1'b1);
    chk({log_write, pin_n}, 2'b00, "link error");
    tick(1);
    chk({view, tag}, {VIEW_ALARM, TAG_LINK_ERR}, "link message");
    rd(REG_STATUS, r);
    chk(r[ST_COMM], 1, "link status");
    // Frozen block must ignore an alarming sample
    tick(PULSE + BLINK);
    ce <= 1'b0;
    smp(250, 100, 1'b0);
    chk({pin_n, led, log_write}, 3'b100, "frozen");
    ce <= 1'b1;
    $display("test alarms done");
    wrap_up();
  end
endmodule
